// ==== hw/ufpc_pkg.sv ====
package ufpc_pkg;

   // Main clock rate.
   localparam int CLK_HZ         = 50_000_000;
   localparam int CLK_PER_US     = CLK_HZ / 1_000_000;

   // Serial frame layout: 8 address bits sent first, then 24 data bits.
   localparam int FRAME_W        = 32;
   localparam int ADDR_W         = 8;
   localparam int DATA_W         = 24;
   localparam int ADDR_LSB       = 24;

   // Data field positions inside the 24 data bits of the counter frame.
   localparam int F_START        = 0;
   localparam int F_GATE_LO      = 1;
   localparam int F_GATE_HI      = 2;
   localparam int F_MODE_0       = 3;
   localparam int F_MODE_1       = 4;
   localparam int F_MODE_2       = 5;
   localparam int F_LOW_EN       = 6;
   localparam int F_HIGH_EN      = 7;
   localparam int F_PERIOD_EN    = 8;
   localparam int F_OUT_SEL      = 9;
   localparam int F_XTAL_SEL     = 10;

   // Address of the counter frame; the value is arbitrary.
   localparam logic [7:0] CTRL_ADDR = 8'hA5;

   // Gate select codes.
   localparam logic [1:0] GATE_1MS    = 2'h0;
   localparam logic [1:0] GATE_4MS    = 2'h1;
   localparam logic [1:0] GATE_16MS   = 2'h2;
   localparam logic [1:0] GATE_MANUAL = 2'h3;

   // Gate times in microseconds and their lengths in main clock cycles.
   localparam int GATE_1MS_US    = 1000;
   localparam int GATE_4MS_US    = 4000;
   localparam int GATE_16MS_US   = 16000;
   localparam int GATE_1MS_CYC   = GATE_1MS_US * CLK_PER_US;
   localparam int GATE_4MS_CYC   = GATE_4MS_US * CLK_PER_US;
   localparam int GATE_16MS_CYC  = GATE_16MS_US * CLK_PER_US;

   // Period measurement pulse rates in hertz and their spacing in cycles.
   localparam int REF_50K_HZ     = 50_000;
   localparam int REF_150K_HZ    = 150_000;
   localparam int REF_900K_HZ    = 900_000;
   localparam int XTAL_LO_HZ     = 4_500_000;
   localparam int XTAL_HI_HZ     = 7_200_000;
   localparam int REF_W          = 10;
   localparam logic [REF_W-1:0] REF_50K_CYC  = REF_W'(CLK_HZ / REF_50K_HZ);
   localparam logic [REF_W-1:0] REF_150K_CYC = REF_W'(CLK_HZ / REF_150K_HZ);
   localparam logic [REF_W-1:0] REF_900K_CYC = REF_W'(CLK_HZ / REF_900K_HZ);
   localparam logic [REF_W-1:0] XTAL_LO_CYC  = REF_W'(CLK_HZ / XTAL_LO_HZ);
   localparam logic [REF_W-1:0] XTAL_HI_CYC  = REF_W'(CLK_HZ / XTAL_HI_HZ);

   // Counter mode codes.
   localparam logic [2:0] MODE_LOW_A   = 3'h0;
   localparam logic [2:0] MODE_LOW_B   = 3'h1;
   localparam logic [2:0] MODE_MID     = 3'h2;
   localparam logic [2:0] MODE_HIGH    = 3'h3;
   localparam logic [2:0] MODE_LOW_C   = 3'h4;
   localparam logic [2:0] MODE_LOW_D   = 3'h5;
   localparam logic [2:0] MODE_PERIOD  = 3'h7;

   // Result counter and prescaler.
   localparam int CNT_W           = 16;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [1:0] PRE_LAST = 2'h3;

   // Counter input source derived from the mode code.
   typedef enum logic [2:0] {
      SRC_NONE   = 3'b000,
      SRC_LOW    = 3'b001,
      SRC_MID    = 3'b010,
      SRC_HIGH   = 3'b011,
      SRC_PERIOD = 3'b100
   } ufpc_src_t;

   // Measurement sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARM   = 2'b01,
      ST_COUNT = 2'b10
   } ufpc_state_t;

endpackage

// ==== hw/ufpc_counter.sv ====
`timescale 1ns/10ps
module ufpc_counter
   import ufpc_pkg::*;
#(
   parameter int GATE_CYC_1MS  = GATE_1MS_CYC,
   parameter int GATE_CYC_4MS  = GATE_4MS_CYC,
   parameter int GATE_CYC_16MS = GATE_16MS_CYC
) (
   // Main clock and reset.
   input  wire logic             mclk,
   input  wire logic             reset,
   // Serial link from the controller.
   input  wire logic             link_clk,
   input  wire logic             serial_data,
   input  wire logic             frame_latch,
   // Counter input pins.
   input  wire logic             low_band_count_in,
   input  wire logic             high_band_count_in,
   input  wire logic             period_count_in,
   // Measurement status.
   output logic [CNT_W-1:0]      count_result,
   output logic                  overflow,
   output logic                  busy,
   // Configuration shown to the pin and port logic.
   output logic                  low_band_pin_en,
   output logic                  high_band_pin_en,
   output logic                  period_input_pin_en,
   output logic                  output_reg_sel,
   output logic                  crystal_sel,
   output logic                  general_out_4_sel
);

   localparam int GATE_W = $clog2(GATE_CYC_16MS + 1);

   // Link domain state.
   logic [1:0]         link_rst_sync;
   logic [1:0]         next_link_rst_sync;
   logic [FRAME_W-1:0] frame_shift;
   logic [FRAME_W-1:0] next_frame_shift;

   // Pin synchronisers: bit 0 strobe, 1 low, 2 high, 3 period.
   logic [3:0]         pin_meta;
   logic [3:0]         pin_sync;
   logic [3:0]         pin_prev;
   logic [3:0]         pin_rise;

   // Control fields taken from the latest counter frame.
   logic               start_bit;
   logic [1:0]         gate_sel;
   logic [2:0]         counter_mode_sel;
   logic               launch_req;
   logic               stop_req;
   logic               next_start_bit;
   logic [1:0]         next_gate_sel;
   logic [2:0]         next_counter_mode_sel;
   logic               next_low_band_pin_en;
   logic               next_high_band_pin_en;
   logic               next_period_input_pin_en;
   logic               next_output_reg_sel;
   logic               next_crystal_sel;
   logic               next_launch_req;
   logic               next_stop_req;
   logic               next_general_out_4_sel;
   logic               frame_hit;

   // Measurement state.
   ufpc_state_t        state;
   ufpc_state_t        next_state;
   ufpc_src_t          src;
   logic [CNT_W-1:0]   next_count_result;
   logic               next_overflow;
   logic [GATE_W-1:0]  gate_cnt;
   logic [GATE_W-1:0]  next_gate_cnt;
   logic [GATE_W-1:0]  gate_limit;
   logic [REF_W-1:0]   ref_cnt;
   logic [REF_W-1:0]   next_ref_cnt;
   logic [REF_W-1:0]   ref_limit;
   logic [1:0]         pre_cnt;
   logic [1:0]         next_pre_cnt;
   logic               ref_tick;
   logic               inc;
   logic               manual;
   logic               next_busy;

   // The link reset is the main reset carried over by two flops on the link clock.
   // The link clock may stop between frames, so the host must clock it a few times
   // across the release of reset; otherwise a link reset that is still pending
   // clears the first bits of the first frame.
   always_comb begin
      next_link_rst_sync = {link_rst_sync[0], reset};
   end

   always_ff @(posedge link_clk) begin
      link_rst_sync <= next_link_rst_sync;
   end

   // Shift in serial bits, address first; the last 32 bits clocked form the frame.
   always_comb begin
      next_frame_shift = {frame_shift[FRAME_W-2:0], serial_data};
      if (link_rst_sync[1]) begin
         next_frame_shift = '0;
      end
   end

   always_ff @(posedge link_clk) begin
      frame_shift <= next_frame_shift;
   end

   // Pins are asynchronous to mclk; the third stage only serves edge detection.
   // Pulses narrower than two mclk periods may be lost, which bounds the input rate.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
         pin_prev <= 4'h0;
      end else begin
         pin_meta <= {period_count_in, high_band_count_in, low_band_count_in, frame_latch};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // The edge stage resets low like the idle pins, so no false edge follows reset.
   assign pin_rise = pin_sync & ~pin_prev;

   // The shift register has been still since the link clock stopped, so the
   // strobe edge seen after two flops qualifies it as a stable word to take over.
   assign frame_hit = pin_rise[0] && (frame_shift[ADDR_LSB +: ADDR_W] == CTRL_ADDR);

   // Latch control fields on each counter frame and raise launch or stop requests.
   always_comb begin
      next_start_bit           = start_bit;
      next_gate_sel            = gate_sel;
      next_counter_mode_sel    = counter_mode_sel;
      next_low_band_pin_en     = low_band_pin_en;
      next_high_band_pin_en    = high_band_pin_en;
      next_period_input_pin_en = period_input_pin_en;
      next_output_reg_sel      = output_reg_sel;
      next_crystal_sel         = crystal_sel;
      next_general_out_4_sel   = general_out_4_sel;
      next_launch_req          = 1'b0;
      next_stop_req            = 1'b0;
      if (frame_hit) begin
         next_start_bit           = frame_shift[F_START];
         next_gate_sel            = {frame_shift[F_GATE_HI], frame_shift[F_GATE_LO]};
         next_counter_mode_sel    = {frame_shift[F_MODE_2], frame_shift[F_MODE_1],
                                     frame_shift[F_MODE_0]};
         next_low_band_pin_en     = frame_shift[F_LOW_EN];
         next_high_band_pin_en    = frame_shift[F_HIGH_EN];
         next_period_input_pin_en = frame_shift[F_PERIOD_EN];
         next_output_reg_sel      = frame_shift[F_OUT_SEL];
         next_crystal_sel         = frame_shift[F_XTAL_SEL];
         // The drive pin becomes a general output for modes 10x.
         next_general_out_4_sel   = ~frame_shift[F_MODE_1] & frame_shift[F_MODE_2];
         next_launch_req          = frame_shift[F_START];
         next_stop_req            = ~frame_shift[F_START];
      end
   end

   // Start, routing and crystal bits power up cleared, and the drive pin
   // stays a loop filter drive until a frame says otherwise.
   always_ff @(posedge mclk) begin
      if (reset) begin
         start_bit           <= 1'b0;
         gate_sel            <= GATE_1MS;
         counter_mode_sel    <= MODE_LOW_A;
         low_band_pin_en     <= 1'b0;
         high_band_pin_en    <= 1'b0;
         period_input_pin_en <= 1'b0;
         output_reg_sel      <= 1'b0;
         crystal_sel         <= 1'b0;
         general_out_4_sel   <= 1'b0;
         launch_req          <= 1'b0;
         stop_req            <= 1'b0;
      end else begin
         start_bit           <= next_start_bit;
         gate_sel            <= next_gate_sel;
         counter_mode_sel    <= next_counter_mode_sel;
         low_band_pin_en     <= next_low_band_pin_en;
         high_band_pin_en    <= next_high_band_pin_en;
         period_input_pin_en <= next_period_input_pin_en;
         output_reg_sel      <= next_output_reg_sel;
         crystal_sel         <= next_crystal_sel;
         general_out_4_sel   <= next_general_out_4_sel;
         launch_req          <= next_launch_req;
         stop_req            <= next_stop_req;
      end
   end

   // Decode the counter source; codes 10x keep the low band of the small variant.
   always_comb begin
      unique case (counter_mode_sel)
         MODE_LOW_A, MODE_LOW_B, MODE_LOW_C, MODE_LOW_D: src = SRC_LOW;
         MODE_MID:                                       src = SRC_MID;
         MODE_HIGH:                                      src = SRC_HIGH;
         MODE_PERIOD:                                    src = SRC_PERIOD;
         default:                                        src = SRC_NONE;
      endcase
   end

   // Gate length and reference pulse spacing follow the gate code.
   always_comb begin
      unique case (gate_sel)
         GATE_1MS: begin
            gate_limit = GATE_W'(GATE_CYC_1MS);
            ref_limit  = REF_50K_CYC;
         end
         GATE_4MS: begin
            gate_limit = GATE_W'(GATE_CYC_4MS);
            ref_limit  = REF_150K_CYC;
         end
         GATE_16MS: begin
            gate_limit = GATE_W'(GATE_CYC_16MS);
            ref_limit  = REF_900K_CYC;
         end
         GATE_MANUAL: begin
            // Manual windows end on a stop frame, or on the second period edge in period mode; this limit is never reached.
            gate_limit = GATE_W'(GATE_CYC_16MS);
            ref_limit  = crystal_sel ? XTAL_HI_CYC : XTAL_LO_CYC;
         end
      endcase
   end

   // Rates that do not divide the main clock are rounded down to whole cycles, so
   // period results read slightly high against the ideal pulse rate.
   assign manual   = (gate_sel == GATE_MANUAL);
   assign ref_tick = (ref_cnt == ref_limit - REF_W'(1));

   // Pick the increment source; a cleared pin enable keeps the pin off the counter.
   always_comb begin
      unique case (src)
         SRC_LOW:    inc = pin_rise[1] & low_band_pin_en;
         SRC_MID:    inc = pin_rise[2] & high_band_pin_en;
         SRC_HIGH:   inc = pin_rise[2] & high_band_pin_en & (pre_cnt == PRE_LAST);
         SRC_PERIOD: inc = ref_tick;
         default:    inc = 1'b0;
      endcase
   end

   // Measurement sequencer. A new launch always wins over any ending window,
   // so a restart frame never leaves a stale result marked finished.
   always_comb begin
      next_state        = state;
      next_count_result = count_result;
      next_overflow     = overflow;
      next_gate_cnt     = gate_cnt;
      next_ref_cnt      = ref_cnt;
      next_pre_cnt      = pre_cnt;
      unique case (state)
         ST_IDLE: begin
            next_state = ST_IDLE;
         end
         ST_ARM: begin
            // Wait for the first rising input edge to open the period window.
            if (pin_rise[3] & period_input_pin_en) begin
               next_state = ST_COUNT;
            end
         end
         ST_COUNT: begin
            // The count saturates at full scale and the flag marks the result unusable,
            // which is cheaper than a seventeenth bit that the host could not read.
            if (inc) begin
               if (count_result == CNT_MAX) begin
                  next_overflow = 1'b1;
               end else begin
                  next_count_result = count_result + CNT_W'(1);
               end
            end
            // The prescaler starts from zero at each launch, so leftover edges never carry.
            if (src == SRC_HIGH && pin_rise[2] && high_band_pin_en) begin
               next_pre_cnt = pre_cnt + 2'h1;
            end
            if (src == SRC_PERIOD) begin
               next_ref_cnt = ref_tick ? '0 : ref_cnt + REF_W'(1);
               if (pin_rise[3] & period_input_pin_en) begin
                  next_state = ST_IDLE;
               end
            end else if (manual) begin
               if (stop_req) begin
                  next_state = ST_IDLE;
               end
            end else begin
               next_gate_cnt = gate_cnt + GATE_W'(1);
               if (gate_cnt == gate_limit - GATE_W'(1)) begin
                  next_state = ST_IDLE;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (launch_req) begin
         next_count_result = '0;
         next_overflow     = 1'b0;
         next_gate_cnt     = '0;
         next_ref_cnt      = '0;
         next_pre_cnt      = 2'h0;
         next_state        = (src == SRC_PERIOD) ? ST_ARM : ST_COUNT;
      end
      // Busy comes from the next state so that it never lags the sequencer.
      next_busy = (next_state != ST_IDLE);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state        <= ST_IDLE;
         count_result <= '0;
         overflow     <= 1'b0;
         gate_cnt     <= '0;
         ref_cnt      <= '0;
         pre_cnt      <= 2'h0;
         busy         <= 1'b0;
      end else begin
         state        <= next_state;
         count_result <= next_count_result;
         overflow     <= next_overflow;
         gate_cnt     <= next_gate_cnt;
         ref_cnt      <= next_ref_cnt;
         pre_cnt      <= next_pre_cnt;
         busy         <= next_busy;
      end
   end

endmodule

// ==== test/ufpc_host_model.sv ====
`timescale 1ns/10ps
module ufpc_host_model
   import ufpc_pkg::*;
(
   // Serial link toward the counter.
   output logic link_clk,
   output logic serial_data,
   output logic frame_latch
);
   // The link clock runs in a burst across the release of reset, so that the
   // link side reset clears, and otherwise only inside frames.
   initial begin
      link_clk    = 1'b0;
      serial_data = 1'b0;
      frame_latch = 1'b0;
      repeat (8) begin
         #15 link_clk = 1'b1;
         #15 link_clk = 1'b0;
      end
   end
   // Address first, most significant bit first, then the latch strobe.
   task automatic send(input logic [7:0] addr, input logic [23:0] data);
      logic [31:0] frame;
      frame = {addr, data};
      // A pause keeps back-to-back frames from moving the data line twice at once.
      #15;
      for (int i = 31; i >= 0; i--) begin
         serial_data = frame[i];
         #15 link_clk = 1'b1;
         #15 link_clk = 1'b0;
      end
      #30 frame_latch = 1'b1;
      #100 frame_latch = 1'b0;
      // Released data is not held, so it shows the inverse of the last bit.
      serial_data = ~frame[0];
   endtask
endmodule

// ==== test/ufpc_counter_assertions.sv ====
`timescale 1ns/10ps
module ufpc_counter_assertions
   import ufpc_pkg::*;
#(
   parameter int GATE_CYC_1MS  = GATE_1MS_CYC,
   parameter int GATE_CYC_4MS  = GATE_4MS_CYC,
   parameter int GATE_CYC_16MS = GATE_16MS_CYC
) (
   // Clock, reset and serial link.
   input wire logic             mclk,
   input wire logic             reset,
   input wire logic             link_clk,
   input wire logic             serial_data,
   input wire logic             frame_latch,
   // Results and configuration.
   input wire logic [CNT_W-1:0] count_result,
   input wire logic             overflow,
   input wire logic             busy,
   input wire logic             low_band_pin_en,
   input wire logic             high_band_pin_en,
   input wire logic             period_input_pin_en,
   input wire logic             output_reg_sel,
   input wire logic             crystal_sel,
   input wire logic             general_out_4_sel
);
   logic [31:0] shadow;
   logic [2:0]  fl_s;
   logic [3:0]  since;
   logic [23:0] frm;
   logic [23:0] lfrm;
   logic        frm_ok;
   logic [19:0] blen;
   logic [19:0] gcyc;
   logic        rise;
   logic        hit;
   // The frame stands still while the latch rises, so mclk may read this mirror.
   always_ff @(posedge link_clk) begin
      shadow <= {shadow[30:0], serial_data};
   end
   // Latch edge, address match and the window length of the launching frame.
   always_comb begin
      rise = fl_s[1] & ~fl_s[2];
      hit  = rise && shadow[31:24] == CTRL_ADDR;
      gcyc = lfrm[F_GATE_HI:F_GATE_LO] == GATE_1MS ? 20'(GATE_CYC_1MS)
           : lfrm[F_GATE_HI:F_GATE_LO] == GATE_4MS ? 20'(GATE_CYC_4MS) : 20'(GATE_CYC_16MS);
   end
   // Last accepted frame, cycles since a latch and length of the busy phase.
   always_ff @(posedge mclk) begin
      if (reset) begin
         fl_s   <= 3'h0;
         since  <= 4'hF;
         frm_ok <= 1'b0;
         blen   <= 20'h00000;
      end else begin
         fl_s  <= {fl_s[1:0], frame_latch};
         since <= rise ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
         blen  <= busy ? blen + 20'h00001 : 20'h00000;
         if (hit) begin
            frm    <= shadow[23:0];
            frm_ok <= 1'b1;
         end
         if (hit && shadow[F_START]) begin
            lfrm <= shadow[23:0];
         end
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   property p_cfg;
      since == 4'h8 && frm_ok |-> {period_input_pin_en, high_band_pin_en, low_band_pin_en}
         == frm[F_PERIOD_EN:F_LOW_EN] && {crystal_sel, output_reg_sel}
         == frm[F_XTAL_SEL:F_OUT_SEL];
   endproperty
   a_cfg: assert property (p_cfg) else $error("config outputs differ from frame");
   property p_go4;
      since == 4'h8 && frm_ok |-> general_out_4_sel == (frm[F_MODE_2] && !frm[F_MODE_1]);
   endproperty
   a_go4: assert property (p_go4) else $error("output pin swap wrong");
   property p_launch;
      hit && shadow[F_START] |-> ##[1:8] (busy && count_result == 16'h0000 && !overflow);
   endproperty
   a_launch: assert property (p_launch) else $error("launch did not clear and run");
   property p_rise;
      $rose(busy) |-> since <= 4'h6;
   endproperty
   a_rise: assert property (p_rise) else $error("busy rose away from a latch");
   property p_gate;
      $fell(busy) && lfrm[F_GATE_HI:F_GATE_LO] != GATE_MANUAL && lfrm[5:3] != MODE_PERIOD
         |-> blen == gcyc;
   endproperty
   a_gate: assert property (p_gate) else $error("window length wrong");
   property p_step;
      $changed(count_result) |-> count_result == 16'h0000
         || count_result == $past(count_result) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("count moved by more than one");
   property p_ovf;
      $rose(overflow) |-> count_result == CNT_MAX;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow before full count");
   property p_quiet;
      !busy && !$past(busy) && since > 4'h8 |-> $stable(count_result) && $stable(overflow);
   endproperty
   a_quiet: assert property (p_quiet) else $error("result moved while idle");
endmodule
bind ufpc_counter ufpc_counter_assertions #(.GATE_CYC_1MS(GATE_CYC_1MS),
   .GATE_CYC_4MS(GATE_CYC_4MS), .GATE_CYC_16MS(GATE_CYC_16MS)) u_chk (
   .mclk(mclk), .reset(reset), .link_clk(link_clk), .serial_data(serial_data),
   .frame_latch(frame_latch), .count_result(count_result), .overflow(overflow),
   .busy(busy), .low_band_pin_en(low_band_pin_en), .high_band_pin_en(high_band_pin_en),
   .period_input_pin_en(period_input_pin_en), .output_reg_sel(output_reg_sel),
   .crystal_sel(crystal_sel), .general_out_4_sel(general_out_4_sel));

// ==== test/universal_freq_period_counter_test.sv ====
`timescale 1ns/10ps
module universal_freq_period_counter_test;
   import ufpc_pkg::*;
   logic        mclk, reset, link_clk, serial_data, frame_latch, busy, overflow, busy_q;
   logic        low_en, high_en, per_en, out_sel, xtal_sel, go4_sel;
   logic [2:0]  pins;
   logic [15:0] count_result;
   logic [31:0] seed;
   logic [15:0] exp_q[$];
   int          n_errors, n_compared, cyc;
   // Short windows of 20, 40 and 80 cycles keep the run brief.
   ufpc_counter #(.GATE_CYC_1MS(20), .GATE_CYC_4MS(40), .GATE_CYC_16MS(80)) uut (
      .mclk(mclk), .reset(reset), .link_clk(link_clk), .serial_data(serial_data),
      .frame_latch(frame_latch), .low_band_count_in(pins[0]), .high_band_count_in(pins[1]),
      .period_count_in(pins[2]), .count_result(count_result), .overflow(overflow),
      .busy(busy), .low_band_pin_en(low_en), .high_band_pin_en(high_en),
      .period_input_pin_en(per_en), .output_reg_sel(out_sel), .crystal_sel(xtal_sel),
      .general_out_4_sel(go4_sel));
   ufpc_host_model host (.link_clk(link_clk), .serial_data(serial_data),
                         .frame_latch(frame_latch));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Output register select stays clear so the count is the readable result.
   function automatic logic [23:0] cfg(logic st, logic [1:0] g, logic [2:0] m,
                                       logic [2:0] en, logic xs);
      return {13'h0000, xs, 1'b0, en, m, g, st};
   endfunction
   task automatic check(logic [15:0] seen, logic [15:0] want);
      n_compared++;
      if (seen !== want) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wait_busy(logic lvl);
      int k;
      k = 0;
      while (busy !== lvl && k < 4000) begin
         @(posedge mclk);
         k++;
      end
      if (k == 4000) begin
         check(16'h0001, 16'h0000);
      end
   endtask
   // Pulses last three cycles each way, well above the two-cycle minimum.
   task automatic pulses(int p, int n);
      @(posedge mclk);
      repeat (n) begin
         pins[p] <= 1'b1;
         repeat (3) @(posedge mclk);
         pins[p] <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask
   task automatic measure(logic [23:0] d, int p, int n, logic [15:0] want);
      exp_q.push_back(want);
      host.send(CTRL_ADDR, d);
      wait_busy(1'b1);
      pulses(p, n);
      wait_busy(1'b0);
   endtask
   // Two rises t cycles apart on the period pin.
   task automatic per_case(logic [1:0] g, logic xs, int t, logic [15:0] want);
      exp_q.push_back(want);
      host.send(CTRL_ADDR, cfg(1'b1, g, MODE_PERIOD, 3'h4, xs));
      wait_busy(1'b1);
      pulses(2, 1);
      repeat (t - 7) @(posedge mclk);
      pulses(2, 1);
      wait_busy(1'b0);
   endtask
   // Each finished measurement is matched against the oldest note.
   always @(negedge mclk) begin
      if (busy_q === 1'b1 && busy === 1'b0) begin
         if (exp_q.size() == 0) begin
            check(16'hFFFF, 16'h0000);
         end else begin
            check(count_result, exp_q.pop_front());
         end
         check(16'(overflow), 16'h0000);
      end
      busy_q = busy;
   end
   // A hang is cut short well after the expected run length.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      logic [23:0] d;
      int n;
      reset = 1'b1;
      pins = 3'h0;
      busy_q = 1'b0;
      seed = 32'h00016B98;
      n_errors = 0;
      n_compared = 0;
      cyc = 0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      // The host's opening link clock burst must be over before the first frame.
      repeat (8) @(posedge mclk);
      // Timed windows, then period cases; the loop's pulse count must fit inside the shortest window.
      for (int g = 0; g < 3; g++) begin
         n = 1 + int'(rnd() % 32'h2);
         measure(cfg(1'b1, 2'(g), MODE_LOW_A, 3'h1, 1'b0), 0, n, 16'(n));
      end
      n = 4 * (1 + int'(rnd() % 32'h3));
      measure(cfg(1'b1, GATE_16MS, MODE_LOW_B, 3'h1, 1'b0), 0, n, 16'(n));
      measure(cfg(1'b1, GATE_16MS, MODE_LOW_C, 3'h1, 1'b0), 0, n, 16'(n));
      measure(cfg(1'b1, GATE_16MS, MODE_LOW_D, 3'h1, 1'b0), 0, n, 16'(n));
      measure(cfg(1'b1, GATE_4MS, MODE_MID, 3'h2, 1'b0), 1, 4, 16'h0004);
      measure(cfg(1'b1, GATE_16MS, MODE_HIGH, 3'h2, 1'b0), 1, n, 16'(n / 4));
      measure(cfg(1'b1, GATE_16MS, MODE_LOW_A, 3'h6, 1'b0), 0, n, 16'h0000);
      measure(cfg(1'b1, GATE_16MS, 3'h6, 3'h7, 1'b0), 0, n, 16'h0000);
      per_case(GATE_1MS, 1'b0, 3500, 16'h0003);
      per_case(GATE_4MS, 1'b0, 1831, 16'h0005);
      per_case(GATE_16MS, 1'b0, 577, 16'h000A);
      per_case(GATE_MANUAL, 1'b0, 115, 16'h000A);
      per_case(GATE_MANUAL, 1'b1, 123, 16'h0014);
      // Host-timed gate over several frames, relaunched once while running.
      exp_q.push_back(16'h0005);
      host.send(CTRL_ADDR, cfg(1'b1, GATE_MANUAL, MODE_LOW_A, 3'h1, 1'b0));
      wait_busy(1'b1);
      pulses(0, 3);
      host.send(CTRL_ADDR, cfg(1'b1, GATE_MANUAL, MODE_LOW_A, 3'h1, 1'b0));
      pulses(0, 5);
      host.send(CTRL_ADDR, cfg(1'b0, GATE_MANUAL, MODE_LOW_A, 3'h1, 1'b0));
      wait_busy(1'b0);
      // Random settings reach the outputs; a frame for another address changes nothing.
      repeat (2) begin
         d = 24'(rnd());
         d[F_START] = 1'b0;
         host.send(CTRL_ADDR, d);
         host.send(8'h5A, ~d);
         repeat (8) @(posedge mclk);
         check(16'({xtal_sel, out_sel, per_en, high_en, low_en}), 16'(d[10:6]));
         check(16'(go4_sel), 16'(d[F_MODE_2] & ~d[F_MODE_1]));
      end
      test_done();
   end
endmodule
